/* File: ssr_pkg.sv */
/*
  Shared constants and types of the serial result readout of the 14-bit
  successive-approximation converter.
  Assumes a single 100 MHz system clock; the serial clock is a sampled input.
*/
package ssr_pkg;

  // ****************************************************************
  // widths and depths
  // ****************************************************************
  localparam int RES_W   = 14;
  localparam int CNT_W   = 6;
  localparam int GAP_W   = 16;
  localparam int FIFO_DEPTH = 32;

  // ****************************************************************
  // frame positions, counted in falling serial clock edges
  // ****************************************************************
  localparam logic [CNT_W-1:0] FALL_SAMPLE_END = 6'h05;
  localparam logic [CNT_W-1:0] FALL_DUMMY_END  = 6'h15;
  localparam logic [CNT_W-1:0] FALL_REV_ZERO   = 6'h16;
  localparam logic [CNT_W-1:0] FALL_REV_FIRST  = 6'h17;
  localparam logic [CNT_W-1:0] FALL_REV_LAST   = 6'h24;
  localparam logic [CNT_W-1:0] FRAME_FALLS     = 6'h18;
  localparam logic [CNT_W-1:0] FALL_SAT        = 6'h3f;

  // ****************************************************************
  // approximation start and reset values
  // ****************************************************************
  localparam logic [RES_W-1:0] TRIAL_START = 14'h2000;
  localparam logic [RES_W-1:0] CODE_RESET  = 14'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ      = 100_000_000;
  localparam int SCLK_MIN_HZ = 24_000;
  localparam int SCLK_MAX_HZ = 1_200_000;
  // longest allowed serial period rounds down, shortest rounds up
  localparam int LEAK_CYCLES_DEF = CLK_HZ / SCLK_MIN_HZ;
  localparam int MIN_PERIOD_CYC  = (CLK_HZ + SCLK_MAX_HZ - 1) / SCLK_MAX_HZ;

  // ****************************************************************
  // frame sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONV   = 4'b0100,
    ST_TAIL   = 4'b1000
  } ssr_state_t;

endpackage : ssr_pkg

/* File: ssr_fifo_if.sv */
/*
  Valid/ready carrier between the frame sequencer and the result FIFO.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface ssr_fifo_if #(
  parameter int W = 14
);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport writer (output push_valid, output push_data, input push_ready,
                  input pop_valid, input pop_data, output pop_ready);
  modport fifo   (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
endinterface : ssr_fifo_if

`default_nettype wire

/* File: ssr_edge.sv */
/*
  Edge finder for a group of inputs that are already synchronous to the
  clock; one registered copy per bit.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_edge #(
  parameter int W = 2
)(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // levels and edges
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] prev_ff;

  // prev resets low, so a line already low at reset shows no falling edge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_ff;
  assign fall_o = ~level_i & prev_ff;
endmodule : ssr_edge

`default_nettype wire

/* File: ssr_fifo.sv */
/*
  Result FIFO with a registered output stage.
  Assumes a single clock; the reader may stall, and push_ready falls when
  the store is full.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
)(
  // clock and reset
  input  wire logic  clock_i,
  input  wire logic  reset_i,
  // stream
  ssr_fifo_if.fifo   q
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          out_valid_ff;
  logic [W-1:0]  out_data_ff;
  logic          push;
  logic          load;

  assign q.push_ready = (count_ff != (AW+1)'(DEPTH));
  assign push         = q.push_valid & q.push_ready;
  assign load         = (count_ff != '0) & (~out_valid_ff | q.pop_ready);
  assign q.pop_valid  = out_valid_ff;
  assign q.pop_data   = out_data_ff;

  // ****************************************************************
  // store
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= q.push_data;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // ****************************************************************
  // output stage, keeps the reader's port straight from flops
  // ****************************************************************
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (q.pop_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule : ssr_fifo

`default_nettype wire

/* File: ssr_top.sv */
/*
  Frame sequencer, successive-approximation control and serial result
  readout of a 14-bit differential converter.
  Assumes select and serial clock are synchronous to clock_i and that the
  analog comparator answers within one system clock of a new trial code.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - result leaves on serial data, one bit per serial clock, MSB first
// - bits in a frame come from that frame's own conversion
// - further clocks after conversion repeat the result LSB first
// - sampling lasts 4.5 serial clock cycles at frame start
// - a frame spans 24 serial clock periods
// - after sampling, hold disconnects both inputs until conversion ends
// - one bit decided per clock, MSB downward, shifted out at once
// - select fall starts sampling; after fifth fall drive low null bit
// - next 16 periods carry result MSB first, periods 15 and 16 zero
// - select high releases output; new frame needs high then low
// - result coded as binary two's complement

module ssr_top
  import ssr_pkg::*;
#(
  parameter int LEAK_CYCLES = LEAK_CYCLES_DEF
)(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  // serial port
  input  wire logic             select_n_i,
  input  wire logic             serial_shift_clock_i,
  output logic                  serial_data_o,
  output logic                  serial_data_oe_o,
  // analog front end
  input  wire logic             cmp_above_i,
  output logic                  sample_o,
  output logic                  hold_o,
  output logic [RES_W-1:0]      trial_code_o,
  // result stream
  output logic [RES_W-1:0]      result_data_o,
  output logic                  result_valid_o,
  input  wire logic             result_ready_i,
  // status
  output logic                  frame_done_o,
  output logic                  rate_error_o,
  output logic                  overrun_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam logic [GAP_W-1:0] LEAK_LIM = GAP_W'(LEAK_CYCLES - 1);
  localparam logic [GAP_W-1:0] FAST_LIM = GAP_W'(MIN_PERIOD_CYC);

  ssr_state_t         state_ff;
  ssr_state_t         nxt_state;
  logic [CNT_W-1:0]   fall_cnt_ff;
  logic [CNT_W-1:0]   fall_num;
  logic [GAP_W-1:0]   gap_cnt_ff;
  logic               sclk_rise;
  logic               sclk_fall;
  logic               sel_rise;
  logic               sel_fall;
  logic               fall_ev;
  logic               decide;
  logic               out_bit;
  logic [RES_W-1:0]   mask_ff;
  logic [RES_W-1:0]   trial_ff;
  logic [RES_W-1:0]   nxt_trial;
  logic [RES_W-1:0]   code_ff;
  logic [RES_W-1:0]   rev_sh_ff;
  logic               sample_ff;
  logic               hold_ff;
  logic               oe_ff;
  logic               data_ff;
  logic               pend_ff;
  logic [RES_W-1:0]   pend_data_ff;
  logic               frame_done_ff;
  logic               rate_err_ff;
  logic               overrun_ff;

  ssr_fifo_if #(.W(RES_W)) res_q ();

  // ****************************************************************
  // edges of the serial lines
  // ****************************************************************
  ssr_edge #(
    .W       (2)
  ) u_edge (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .level_i ({select_n_i, serial_shift_clock_i}),
    .rise_o  ({sel_rise, sclk_rise}),
    .fall_o  ({sel_fall, sclk_fall})
  );

  // clocks outside a frame, or with select high, have no effect
  assign fall_ev  = sclk_fall & ~select_n_i & (state_ff != ST_IDLE);
  assign fall_num = fall_cnt_ff + 6'h01;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (sel_fall) begin
          nxt_state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (fall_ev && fall_num == FALL_SAMPLE_END) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (fall_ev && fall_num == FALL_DUMMY_END) begin
          nxt_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        nxt_state = ST_TAIL;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (select_n_i) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // falls are counted from the select edge; the count saturates
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      fall_cnt_ff <= '0;
    end else if (sel_fall) begin
      fall_cnt_ff <= '0;
    end else if (fall_ev && fall_cnt_ff != FALL_SAT) begin
      fall_cnt_ff <= fall_num;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= fall_ev & (fall_num == FRAME_FALLS);
    end
  end

  // ****************************************************************
  // sample and hold switches
  // ****************************************************************
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sample_ff <= 1'b0;
    end else if (select_n_i) begin
      sample_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && sel_fall) begin
      sample_ff <= 1'b1;
    end else if (fall_ev && fall_num == FALL_SAMPLE_END) begin
      sample_ff <= 1'b0;
    end
  end

  // an aborted frame also opens the hold, the result is lost anyway
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      hold_ff <= 1'b0;
    end else if (select_n_i) begin
      hold_ff <= 1'b0;
    end else if (fall_ev && fall_num == FALL_SAMPLE_END) begin
      hold_ff <= 1'b1;
    end else if (fall_ev && fall_num == FALL_DUMMY_END) begin
      hold_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // successive approximation
  // ****************************************************************
  assign decide  = fall_ev & (state_ff == ST_CONV) & (mask_ff != '0);
  // offset-binary decision, top bit inverted gives two's complement
  assign out_bit = mask_ff[RES_W-1] ? ~cmp_above_i : cmp_above_i;
  assign nxt_trial = (cmp_above_i ? trial_ff : (trial_ff & ~mask_ff))
                     | (mask_ff >> 1);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mask_ff  <= CODE_RESET;
      trial_ff <= TRIAL_START;
      code_ff  <= CODE_RESET;
    end else if (fall_ev && fall_num == FALL_SAMPLE_END) begin
      // fresh start each frame, nothing carries over from the last one
      mask_ff  <= TRIAL_START;
      trial_ff <= TRIAL_START;
      code_ff  <= CODE_RESET;
    end else if (decide) begin
      mask_ff  <= mask_ff >> 1;
      trial_ff <= nxt_trial;
      code_ff  <= (code_ff & ~mask_ff) | ({RES_W{out_bit}} & mask_ff);
    end
  end

  // copy of the result for the least-significant-first repeat
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rev_sh_ff <= CODE_RESET;
    end else if (fall_ev && fall_num == FALL_REV_ZERO) begin
      rev_sh_ff <= code_ff;
    end else if (fall_ev && fall_num >= FALL_REV_FIRST
                 && fall_num <= FALL_REV_LAST) begin
      rev_sh_ff <= rev_sh_ff >> 1;
    end
  end

  // ****************************************************************
  // serial data pin
  // ****************************************************************
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      oe_ff <= 1'b0;
    end else if (select_n_i) begin
      oe_ff <= 1'b0;
    end else if (fall_ev && fall_num == FALL_SAMPLE_END) begin
      oe_ff <= 1'b1;
    end
  end

  // each bit is launched on a falling edge and stands a whole period
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      data_ff <= 1'b0;
    end else if (select_n_i) begin
      data_ff <= 1'b0;
    end else if (fall_ev) begin
      if (decide) begin
        data_ff <= out_bit;
      end else if (fall_num >= FALL_REV_FIRST && fall_num <= FALL_REV_LAST) begin
        data_ff <= rev_sh_ff[0];
      end else begin
        // null bit, dummy bits, leading zero of the repeat and beyond
        data_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // result hand-off to the FIFO
  // ****************************************************************
  // a full FIFO stalls the hand-off; a second result overwrites the first
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pend_ff      <= 1'b0;
      pend_data_ff <= CODE_RESET;
    end else if (fall_ev && fall_num == FALL_DUMMY_END) begin
      pend_ff      <= 1'b1;
      pend_data_ff <= code_ff;
    end else if (res_q.push_ready) begin
      pend_ff      <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      overrun_ff <= 1'b0;
    end else if (fall_ev && fall_num == FALL_DUMMY_END
                 && pend_ff && !res_q.push_ready) begin
      overrun_ff <= 1'b1;
    end
  end

  assign res_q.push_valid = pend_ff;
  assign res_q.push_data  = pend_data_ff;
  assign res_q.pop_ready  = result_ready_i;

  ssr_fifo #(
    .W       (RES_W),
    .DEPTH   (FIFO_DEPTH)
  ) u_fifo (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .q       (res_q)
  );

  // ****************************************************************
  // serial clock rate watch
  // ****************************************************************
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt_ff <= '0;
    end else if (sel_fall || fall_ev) begin
      gap_cnt_ff <= '0;
    end else if (state_ff != ST_IDLE && gap_cnt_ff != LEAK_LIM) begin
      gap_cnt_ff <= gap_cnt_ff + 16'h0001;
    end
  end

  // too slow lets held charge leak; flag per frame, set wins over clear
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rate_err_ff <= 1'b0;
    end else if (state_ff != ST_IDLE && !select_n_i
                 && gap_cnt_ff == LEAK_LIM) begin
      rate_err_ff <= 1'b1;
    // gap reads one less than the fall-to-fall period
    end else if (fall_ev && fall_num != 6'h01
                 && (gap_cnt_ff + 16'h0001) < FAST_LIM) begin
      rate_err_ff <= 1'b1;
    end else if (sel_fall) begin
      rate_err_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign serial_data_o    = data_ff;
  assign serial_data_oe_o = oe_ff;
  assign sample_o         = sample_ff;
  assign hold_o           = hold_ff;
  assign trial_code_o     = trial_ff;
  assign result_data_o    = res_q.pop_data;
  assign result_valid_o   = res_q.pop_valid;
  assign frame_done_o     = frame_done_ff;
  assign rate_error_o     = rate_err_ff;
  assign overrun_o        = overrun_ff;

endmodule : ssr_top

`default_nettype wire

/* File: ssr_top_sva.sv */
/*
  Checker of the serial readout top, watching its ports only.
  Assumes select and serial clock are sampled by clock_i like the device.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_top_sva
  import ssr_pkg::*;
#(
  parameter int LEAK_CYCLES = LEAK_CYCLES_DEF
)(
  // clock and reset
  input wire logic             clock_i,
  input wire logic             reset_i,
  // serial port
  input wire logic             select_n_i,
  input wire logic             serial_shift_clock_i,
  input wire logic             serial_data_o,
  input wire logic             serial_data_oe_o,
  // analog front end
  input wire logic             cmp_above_i,
  input wire logic             sample_o,
  input wire logic             hold_o,
  input wire logic [RES_W-1:0] trial_code_o,
  // result stream and status
  input wire logic [RES_W-1:0] result_data_o,
  input wire logic             result_valid_o,
  input wire logic             result_ready_i,
  input wire logic             frame_done_o,
  input wire logic             rate_error_o,
  input wire logic             overrun_o
);
  // ****************************************************************
  // serial falls of the current frame
  // ****************************************************************
  logic       sclk_ff;
  logic [5:0] falls_ff;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) sclk_ff <= 1'b0;
    else sclk_ff <= serial_shift_clock_i;
  end

  // counted one sample behind, as the device sees them
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) falls_ff <= 6'h00;
    else if (select_n_i) falls_ff <= 6'h00;
    else if (sclk_ff && !serial_shift_clock_i && falls_ff != 6'h3f)
      falls_ff <= falls_ff + 6'h01;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_phase_excl;
    !(sample_o && hold_o);
  endproperty
  a_phase_excl: assert property (p_phase_excl)
    else $error("sample and hold both high");

  property p_sample_start;
    $rose(sample_o) |-> !select_n_i && falls_ff == 6'h00;
  endproperty
  a_sample_start: assert property (p_sample_start)
    else $error("sampling began without select fall");

  property p_sample_end;
    $rose(hold_o) |-> $fell(sample_o) && falls_ff == 6'h05
      && trial_code_o == TRIAL_START;
  endproperty
  a_sample_end: assert property (p_sample_end)
    else $error("hold began at wrong fall");

  property p_oe_start;
    $rose(serial_data_oe_o) |-> falls_ff == 6'h05 && hold_o && !serial_data_o;
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("output enabled at wrong fall");

  property p_hold_span;
    $fell(hold_o) && !select_n_i |-> falls_ff == 6'h15;
  endproperty
  a_hold_span: assert property (p_hold_span)
    else $error("hold ended at wrong fall");

  property p_hold_oe;
    hold_o |-> serial_data_oe_o;
  endproperty
  a_hold_oe: assert property (p_hold_oe)
    else $error("output off during hold");

  property p_bits;
    falls_ff >= 6'h06 && falls_ff <= 6'h13 && $past(falls_ff) == falls_ff
      && $past(falls_ff, 2) == falls_ff - 6'h01
      |-> serial_data_o == ($past(cmp_above_i, 2) ^ (falls_ff == 6'h06));
  endproperty
  a_bits: assert property (p_bits)
    else $error("decided bit not shifted out");

  property p_zeros;
    serial_data_oe_o && $stable(falls_ff) && (falls_ff == 6'h05
      || (falls_ff >= 6'h14 && falls_ff <= 6'h16) || falls_ff > 6'h24)
      |-> !serial_data_o;
  endproperty
  a_zeros: assert property (p_zeros)
    else $error("null or dummy bit not zero");

  property p_release;
    $rose(select_n_i) |-> ##[1:2] !serial_data_oe_o;
  endproperty
  a_release: assert property (p_release)
    else $error("output not released");

  property p_done;
    frame_done_o |-> falls_ff == 6'h18 ##1 !frame_done_o;
  endproperty
  a_done: assert property (p_done)
    else $error("frame end pulse wrong");
endmodule : ssr_top_sva

bind ssr_top ssr_top_sva #(.LEAK_CYCLES(LEAK_CYCLES)) i_sva (
  .clock_i(clock_i), .reset_i(reset_i), .select_n_i(select_n_i),
  .serial_shift_clock_i(serial_shift_clock_i),
  .serial_data_o(serial_data_o), .serial_data_oe_o(serial_data_oe_o),
  .cmp_above_i(cmp_above_i), .sample_o(sample_o), .hold_o(hold_o),
  .trial_code_o(trial_code_o), .result_data_o(result_data_o),
  .result_valid_o(result_valid_o), .result_ready_i(result_ready_i),
  .frame_done_o(frame_done_o), .rate_error_o(rate_error_o),
  .overrun_o(overrun_o));

`default_nettype wire

/* File: ssr_ctl_model.sv */
/*
  Behavioural serial master: select, serial clock and bit capture.
  Assumes the bench resolves the data pin and raises start_i until busy.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_ctl_model (
  // clock
  input  wire logic       clock_i,
  // request
  input  wire logic       start_i,
  input  wire logic [7:0] half_i,
  input  wire logic [5:0] falls_i,
  // serial port
  input  wire logic       pin_i,
  output logic            select_n_o,
  output logic            sclk_o,
  // status
  output logic            busy_o,
  output logic            done_o,
  output logic [47:0]     cap_o
);
  int k;

  initial begin
    select_n_o = 1'b1;
    sclk_o     = 1'b0;
    busy_o     = 1'b0;
    done_o     = 1'b0;
    cap_o      = '0;
  end

  // serial clock stands low between frames; its last fall comes 4 clocks after select rises
  always begin
    @(posedge clock_i);
    if (start_i) begin
      #1;
      busy_o     = 1'b1;
      cap_o      = '0;
      select_n_o = 1'b0;
      repeat (half_i) @(posedge clock_i);
      for (k = 0; k <= falls_i; k++) begin
        #1;
        sclk_o = 1'b1;
        if (k > 0) cap_o[k] = pin_i;
        repeat (half_i) @(posedge clock_i);
        if (k < falls_i) begin
          #1;
          sclk_o = 1'b0;
          repeat (half_i) @(posedge clock_i);
        end
      end
      #1;
      select_n_o = 1'b1;
      repeat (4) @(posedge clock_i);
      #1;
      sclk_o = 1'b0;
      done_o = 1'b1;
      @(posedge clock_i);
      #1;
      done_o = 1'b0;
      busy_o = 1'b0;
    end
  end
endmodule : ssr_ctl_model

`default_nettype wire

/* File: ssr_top_tb_top.sv */
/*
  Self-checking bench of ssr_top: serial master model on the pin side,
  comparator model and a stalling result reader on the other side.
*/
`timescale 1ns/1ps
`default_nettype none

module ssr_top_tb_top;
  import ssr_pkg::*;
  logic             clock_i, reset_i, select_n, sclk, sdo, sdo_oe, cmp;
  logic             sample, hold, fdone, rate_err, overrun, valid, ready;
  logic [RES_W-1:0] trial, rdata, ain;
  logic             pin, pin_last, start, busy, mdone, stall, extra;
  logic [7:0]       half;
  logic [5:0]       nfalls;
  logic [47:0]      cap;
  logic [31:0]      seed, seed2;
  logic [RES_W-1:0] exp_str[$];
  logic [RES_W-1:0] exp_ser[$];
  int               exp_nf[$];
  int               err_total, n_checks, i, n;

  ssr_top #(.LEAK_CYCLES(200)) i_dut (
    .clock_i(clock_i), .reset_i(reset_i), .select_n_i(select_n),
    .serial_shift_clock_i(sclk), .serial_data_o(sdo),
    .serial_data_oe_o(sdo_oe), .cmp_above_i(cmp), .sample_o(sample),
    .hold_o(hold), .trial_code_o(trial), .result_data_o(rdata),
    .result_valid_o(valid), .result_ready_i(ready),
    .frame_done_o(fdone), .rate_error_o(rate_err), .overrun_o(overrun));

  ssr_ctl_model i_master (
    .clock_i(clock_i), .start_i(start), .half_i(half), .falls_i(nfalls),
    .pin_i(pin), .select_n_o(select_n), .sclk_o(sclk), .busy_o(busy),
    .done_o(mdone), .cap_o(cap));

  // a released pin shows the inverse of its last bit, never a clean value
  assign pin = (sdo_oe === 1'b1) ? sdo : ~pin_last;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (sdo_oe === 1'b1) pin_last <= sdo;
  // comparator model: offset-binary input against the trial code
  always @(posedge clock_i) #1 cmp = (ain >= trial);
  always @(posedge clock_i) begin
    #1;
    seed2 = lfsr(seed2);
    ready = !stall && seed2[3];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task report_and_stop;
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task fail(input string m);
    err_total++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : fail

  task chk_word(input logic [13:0] got, input logic [13:0] e);
    n_checks++;
    if (got !== e) fail("result word");
  endtask : chk_word

  task chk_bit(input logic got, input logic e);
    n_checks++;
    if (got !== e) fail("status flag");
  endtask : chk_bit

  task chk_ser(input logic [13:0] e, input int nf, input logic [47:0] c);
    int  k;
    logic b;
    for (k = 5; k <= nf; k++) begin
      if (k >= 6 && k <= 19) b = e[19-k];
      else if (k >= 23 && k <= 36) b = e[k-23];
      else b = 1'b0;
      n_checks++;
      if (c[k] !== b) fail("serial bit");
    end
  endtask : chk_ser

  // expected code is the input with its top bit inverted
  task frame(input logic [13:0] a, input int nf, input int h, input bit s);
    int w;
    @(posedge clock_i);
    #1;
    ain = a;
    if (nf >= 22) exp_ser.push_back(a ^ 14'h2000);
    if (nf >= 22) exp_nf.push_back(nf);
    if (s) exp_str.push_back(a ^ 14'h2000);
    half   = 8'(h);
    nfalls = 6'(nf);
    start  = 1'b1;
    w = 0;
    while (busy !== 1'b1 && w < 8) begin
      @(posedge clock_i);
      w++;
    end
    if (busy !== 1'b1) fail("no start");
    #1;
    start = 1'b0;
    while (mdone !== 1'b1 && w < 20000) begin
      @(posedge clock_i);
      w++;
    end
    if (w >= 20000) begin
      fail("frame timeout");
      report_and_stop();
    end
    #2;
  endtask : frame

  always @(posedge clock_i) begin
    if (mdone === 1'b1 && exp_ser.size() > 0)
      chk_ser(exp_ser.pop_front(), exp_nf.pop_front(), cap);
    if (valid === 1'b1 && ready === 1'b1) begin
      if (exp_str.size() > 0) chk_word(rdata, exp_str.pop_front());
      else if (!extra) fail("result without a frame");
    end
  end

  initial begin
    clock_i   = 1'b0;
    reset_i   = 1'b1;
    {start, cmp, ready, pin_last, stall, extra} = '0;
    ain       = '0;
    half      = 8'h2a;
    nfalls    = 6'h18;
    seed      = 32'hca8a;
    seed2     = 32'hca8a;
    err_total = 0;
    n_checks  = 0;
    repeat (20) @(posedge clock_i);
    #1;
    reset_i = 1'b0;
    repeat (3) @(posedge clock_i);
    frame(14'h0000, 36, 42, 1);
    frame(14'h3fff, 36, 42, 1);
    for (i = 0; i < 2; i++) begin
      seed = lfsr(lfsr(seed));
      frame(seed[13:0], 36, 42, 1);
    end
    seed = lfsr(lfsr(seed));
    frame(seed[13:0], 24, 110, 1);
    chk_bit(rate_err, 1'b1);
    frame(14'h1555, 8, 30, 0);
    chk_bit(rate_err, 1'b1);
    seed = lfsr(lfsr(seed));
    frame(seed[13:0], 24, 42, 1);
    chk_bit(rate_err, 1'b0);
    // reader stalls while the store and output stage fill past their 33 places
    stall = 1'b1;
    for (i = 0; i < 35; i++) begin
      seed = lfsr(lfsr(seed));
      frame(seed[13:0], 22, 42, i < 33);
    end
    chk_bit(overrun, 1'b1);
    extra = 1'b1;
    stall = 1'b0;
    n = 0;
    while ((exp_str.size() > 0 || valid === 1'b1) && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 2000) fail("drain timeout");
    report_and_stop();
  end
endmodule : ssr_top_tb_top

`default_nettype wire
